// ---- hw/cssw_top.sv ----
`timescale 1ns/100ps
`include "cssw_map.svh"

// Operation
// [RULE_01] high-frequency crystal mode from select bits 3:1
// [RULE_02] select bit0 low: crystal start-up table
// [RULE_03] select bit0 high: crystal start-up table
// [RULE_04] short-delay crystal settings need reset pin
// [RULE_05] low-frequency crystal start-up table, 11 reserved
// [RULE_06] timer may start low-frequency oscillator
// [RULE_07] external clock: 6 cycles plus reset delay
// [RULE_08] external code 00 adds 4.1 ms if fuse
// [RULE_09] timer may enable external clock input
// [RULE_10] system clock on output pin when enabled; the code keeps the pin off while the active source is the lf or hf crystal
// [RULE_11] no clock on output pin during reset
// [RULE_12] output pin carries the divided system clock
// [RULE_13] glitch-free run-time source enable and disable
// [RULE_14] command register needs two-step guarded write
// [RULE_15] decode commands, one operation at a time
// [RULE_16] five commands: disable enable request switch recover
// [RULE_17] fuses copied into selection register at reset
// [RULE_18] clock-out bit holds inverted fuse value
// [RULE_19] reset delay: 512 or 8192 watchdog cycles
// [RULE_20] ready cleared at count start, set at limit
// [RULE_21] hold execution until start-up and delay done
module cssw_top
  import cssw_pkg::*;
#(
  parameter logic [16:0] SRC_CK_16K = `CSSW_CK_16K,
  parameter logic [16:0] SRC_CK_32K = `CSSW_CK_32K,
  parameter logic [15:0] WDT_LONG = `CSSW_WDT_LONG
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // raw source clocks: rc, wdt, ext, lf, hf
  input wire logic [4:0] src_clk_i,
  // fuses
  input wire logic [3:0] source_select_fuse_i,
  input wire logic [1:0] startup_fuse_i,
  input wire logic clock_out_fuse_i,
  input wire logic reset_pin_disable_fuse_i,
  // asynchronous timer requests
  input wire logic tmr_lf_req_i,
  input wire logic tmr_ext_req_i,
  // core side
  input wire logic wake_i,
  input wire logic sysclk_div_i,
  // source control
  output logic [4:0] src_en_o,
  output logic [1:0] hf_mode_o,
  output logic [2:0] sys_src_o,
  output logic cpu_hold_o,
  // clock output pin
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe_o
);

  // ---------------------------------------------------------------
  // source decode and start-up tables
  // ---------------------------------------------------------------
  function automatic logic [2:0] src_idx(input logic [3:0] sel);
    logic [2:0] r;
    r = `CSSW_IDX_EXT;
    if (sel[3]) begin
      r = `CSSW_IDX_HF;
    end else if (sel[3:1] == `CSSW_CODE_LF_HI) begin
      r = `CSSW_IDX_LF;
    end else if (sel == `CSSW_CODE_RC) begin
      r = `CSSW_IDX_RC;
    end else if (sel == `CSSW_CODE_WDT) begin
      r = `CSSW_IDX_WDT;
    end
    return r;
  endfunction : src_idx

  // source cycles to count; boot adds the 14-cycle reset part, except on the low-frequency crystal
  function automatic logic [16:0] start_lim(input logic [3:0] sel,
                                            input logic [1:0] sut,
                                            input logic boot);
    logic [16:0] r;
    logic [2:0] k;
    k = {sel[0], sut};
    r = `CSSW_CK_6; // RULE_07
    if (sel[3]) begin
      unique case (k)
        3'h0, 3'h1: r = `CSSW_CK_258; // RULE_02
        3'h2, 3'h3: r = `CSSW_CK_1K; // RULE_02
        3'h4: r = `CSSW_CK_1K; // RULE_03
        3'h5, 3'h6, 3'h7: r = SRC_CK_16K; // RULE_03
      endcase
    end else if (sel[3:1] == `CSSW_CODE_LF_HI) begin
      // reserved code 11 behaves as 10
      r = sut[1] ? SRC_CK_32K : `CSSW_CK_1K; // RULE_05
    end
    if (boot && (sel[3:1] != `CSSW_CODE_LF_HI)) begin
      r = r + `CSSW_CK_14;
    end
    return r;
  endfunction : start_lim

  // extra delay from reset, timed by the watchdog oscillator
  function automatic cssw_dly_t rst_dly(input logic [3:0] sel,
                                        input logic [1:0] sut,
                                        input logic rdis);
    cssw_dly_t r;
    logic [2:0] k;
    k = {sel[0], sut};
    r = CSSW_DLY_LONG;
    if (sel[3]) begin
      unique case (k)
        3'h0, 3'h3, 3'h6: r = CSSW_DLY_SHORT; // RULE_02 RULE_03
        3'h1, 3'h4, 3'h7: r = CSSW_DLY_LONG; // RULE_02 RULE_03
        // 14-cycle-only settings take the short delay when the reset pin is disabled
        3'h2, 3'h5: r = rdis ? CSSW_DLY_SHORT : CSSW_DLY_NONE; // RULE_04
      endcase
    end else if (sel[3:1] == `CSSW_CODE_LF_HI) begin
      r = (sut == 2'h0) ? CSSW_DLY_SHORT : CSSW_DLY_LONG; // RULE_05
    end else begin
      unique case (sut)
        2'h0: r = rdis ? CSSW_DLY_SHORT : CSSW_DLY_NONE; // RULE_08
        2'h1: r = CSSW_DLY_SHORT; // RULE_07
        2'h2, 2'h3: r = CSSW_DLY_LONG; // RULE_07
      endcase
    end
    return r;
  endfunction : rst_dly

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cssw_regs_t q;
  cssw_regs_t d;
  cssw_regs_t rst_val;

  logic [4:0] edge_v;
  logic req;
  logic acc;
  logic wr_ok;
  logic [7:0] wb;
  logic [2:0] sidx;
  logic [2:0] aidx;
  logic [4:0] tmr_en;
  logic ck_en;
  cssw_dly_t bdly;
  cssw_cmd_t cmd;

  always_comb begin
    rst_val = '0;
    rst_val.state = CSSW_ST_INIT;
    rst_val.source_select_field = `CSSW_SEL_RESET;
    rst_val.startup_field = `CSSW_SUT_RESET;
    rst_val.wait_n = 1'b1;
    rst_val.hold = 1'b1;
  end

  // edges of the synchronised source clocks; only stage two and
  // three are looked at
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_edge
      assign edge_v[gi] = q.ck_s2[gi] & ~q.ck_s3[gi];
    end
  endgenerate

  always_comb begin
    d = q;
    req = avs_read_i | avs_write_i;
    acc = req & ~q.wait_n;
    wr_ok = acc & avs_write_i & avs_byteenable_i[0];
    wb = avs_writedata_i[7:0];
    sidx = src_idx(q.source_select_field);
    aidx = src_idx(q.active);
    bdly = rst_dly(q.fz_s2[3:0], q.fz_s2[5:4], q.fz_s2[7]);
    cmd = cssw_cmd_t'(wb[3:0]);
    tmr_en = '0;

    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    d.ck_s1 = src_clk_i;
    d.ck_s2 = q.ck_s1;
    d.ck_s3 = q.ck_s2;
    d.fz_s1 = {reset_pin_disable_fuse_i, clock_out_fuse_i,
               startup_fuse_i, source_select_fuse_i};
    d.fz_s2 = q.fz_s1;
    d.tm_s1 = {tmr_ext_req_i, tmr_lf_req_i};
    d.tm_s2 = q.tm_s1;

    // -------------------------------------------------------------
    // boot sequence
    // -------------------------------------------------------------
    unique case (q.state)
      CSSW_ST_INIT: begin
        // wait until the fuse synchroniser carries settled values
        if (q.init_cnt == `CSSW_INIT_WAIT) begin
          d.source_select_field = q.fz_s2[3:0]; // RULE_17
          d.startup_field = q.fz_s2[5:4]; // RULE_17
          d.clock_out_bit = ~q.fz_s2[6]; // RULE_18
          d.rstdis = q.fz_s2[7];
          d.active = q.fz_s2[3:0];
          d.src_en[src_idx(q.fz_s2[3:0])] = 1'b1;
          d.cidx = src_idx(q.fz_s2[3:0]);
          d.limit = start_lim(q.fz_s2[3:0], q.fz_s2[5:4], 1'b1);
          d.cnt = '0;
          d.wcnt = '0;
          d.wlimit = (bdly == CSSW_DLY_SHORT) ? `CSSW_WDT_SHORT
                                              : WDT_LONG; // RULE_19
          d.state = (bdly == CSSW_DLY_NONE) ? CSSW_ST_START
                                            : CSSW_ST_RDLY;
        end else begin
          d.init_cnt = q.init_cnt + 2'h1;
        end
      end
      CSSW_ST_RDLY: begin
        if (edge_v[`CSSW_IDX_WDT]) begin
          d.wcnt = q.wcnt + 16'h0001;
          if (d.wcnt == q.wlimit) begin
            d.state = CSSW_ST_START; // RULE_19
          end
        end
      end
      CSSW_ST_START: begin
        if (edge_v[q.cidx]) begin
          d.cnt = q.cnt + 17'h00001;
          if (d.cnt == q.limit) begin
            d.state = CSSW_ST_RUN; // RULE_21
            d.rdy = 1'b1;
          end
        end
      end
      CSSW_ST_RUN: begin
        // wake-up re-times the source without the reset delay
        if (wake_i) begin
          d.cidx = aidx;
          d.limit = start_lim(q.active, q.startup_field, 1'b0);
          d.cnt = '0;
          d.busy = 1'b0;
          d.state = CSSW_ST_START; // RULE_21
        end
      end
    endcase
    d.hold = (d.state != CSSW_ST_RUN); // RULE_21

    // -------------------------------------------------------------
    // availability counter
    // -------------------------------------------------------------
    if (q.busy && edge_v[q.cidx]) begin
      d.cnt = q.cnt + 17'h00001;
      if (d.cnt == q.limit) begin
        d.busy = 1'b0;
        d.rdy = 1'b1; // RULE_20
      end
    end

    // -------------------------------------------------------------
    // register writes and guarded command port
    // -------------------------------------------------------------
    if (q.cce_win != 3'h0) begin
      d.cce_win = q.cce_win - 3'h1;
    end else begin
      d.cce = 1'b0; // RULE_14
    end
    if (wr_ok && (avs_address_i == `CSSW_ADR_SEL)) begin
      d.source_select_field = wb[3:0];
      d.startup_field = wb[`CSSW_SEL_STARTUP_FIELD_LSB +: 2];
      d.clock_out_bit = wb[`CSSW_SEL_CLOCK_OUT_BIT_BIT];
    end
    if (wr_ok && (avs_address_i == `CSSW_ADR_CMD)) begin
      if (wb == 8'h80) begin
        d.cce = 1'b1; // RULE_14
        d.cce_win = `CSSW_CCE_WIN;
      end else if (q.cce && !wb[`CSSW_CMD_CCE_BIT]) begin
        d.cce = 1'b0;
        d.cce_win = 3'h0;
        // one operation at a time: nothing launches while busy
        if (!q.busy && (q.state == CSSW_ST_RUN)) begin // RULE_15
          unique case (cmd)
            CSSW_CMD_DIS: begin
              if (sidx != aidx) begin // RULE_16
                d.src_en[sidx] = 1'b0; // RULE_13
              end
            end
            CSSW_CMD_EN, CSSW_CMD_REQ: begin
              if (cmd == CSSW_CMD_EN) begin
                d.src_en[sidx] = 1'b1; // RULE_13
              end
              d.cidx = sidx;
              d.limit = start_lim(q.source_select_field, q.startup_field, 1'b0);
              d.cnt = '0;
              d.busy = 1'b1;
              d.rdy = 1'b0; // RULE_20
            end
            CSSW_CMD_SW: begin
              if (q.src_en[sidx] && q.rdy) begin // RULE_16
                d.active = q.source_select_field;
              end
            end
            CSSW_CMD_REC: d.source_select_field = q.active; // RULE_16
            default: d.cce = 1'b0;
          endcase
        end
      end
    end

    // -------------------------------------------------------------
    // source enables, timer sharing, mode
    // -------------------------------------------------------------
    tmr_en[`CSSW_IDX_LF] = q.tm_s2[0] & ~(q.src_en[`CSSW_IDX_HF] &
                           q.src_en[`CSSW_IDX_EXT]); // RULE_06
    tmr_en[`CSSW_IDX_EXT] = q.tm_s2[1] & ~q.src_en[`CSSW_IDX_HF] &
                            ~q.src_en[`CSSW_IDX_LF]; // RULE_09
    // enables change only from registers, so a pad never sees a runt
    d.oen = q.src_en | tmr_en; // RULE_13
    d.hf_mode = q.source_select_field[3] ? q.source_select_field[2:1] : 2'h0; // RULE_01
    d.sys_idx = aidx;

    // -------------------------------------------------------------
    // clock output pin
    // -------------------------------------------------------------
    ck_en = q.clock_out_bit && !q.hold && (aidx != `CSSW_IDX_HF) &&
            (aidx != `CSSW_IDX_LF); // RULE_10 RULE_11
    d.ck_oe = ck_en; // RULE_10
    d.ck_out = ck_en & sysclk_div_i; // RULE_12

    // -------------------------------------------------------------
    // bus answer: one wait cycle, read data captured alongside
    // -------------------------------------------------------------
    d.wait_n = ~(req & q.wait_n);
    if (req && q.wait_n) begin
      d.rdata = '0;
      unique case (avs_address_i)
        `CSSW_ADR_SEL: d.rdata[6:0] = {q.clock_out_bit, q.startup_field, q.source_select_field};
        `CSSW_ADR_CMD: begin
          d.rdata[`CSSW_CMD_CCE_BIT] = q.cce;
          d.rdata[`CSSW_CMD_RDY_BIT] = q.rdy; // RULE_20
        end
        `CSSW_ADR_STAT: d.rdata[15:0] = {q.busy, q.hold, q.state,
                                          q.active, 3'h0, q.oen};
        default: d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_n;
  assign src_en_o = q.oen;
  assign hf_mode_o = q.hf_mode;
  assign sys_src_o = q.sys_idx;
  assign cpu_hold_o = q.hold;
  assign clock_output_pin_o = q.ck_out;
  assign clock_output_pin_oe_o = q.ck_oe;

endmodule : cssw_top

// ---- hw/cssw_map.svh ----
`ifndef CSSW_MAP_SVH
`define CSSW_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CSSW_ADR_SEL 4'h0
`define CSSW_ADR_CMD 4'h4
`define CSSW_ADR_STAT 4'h8

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define CSSW_SEL_STARTUP_FIELD_LSB 4
`define CSSW_SEL_CLOCK_OUT_BIT_BIT 6
`define CSSW_CMD_CCE_BIT 7
`define CSSW_CMD_RDY_BIT 4
`define CSSW_SEL_RESET 4'h2
`define CSSW_SUT_RESET 2'h2

// ---------------------------------------------------------------
// source codes and enable indices
// ---------------------------------------------------------------
`define CSSW_CODE_EXT 4'h0
`define CSSW_CODE_RC 4'h2
`define CSSW_CODE_WDT 4'h3
`define CSSW_CODE_LF_HI 3'h2
`define CSSW_IDX_RC 3'h0
`define CSSW_IDX_WDT 3'h1
`define CSSW_IDX_EXT 3'h2
`define CSSW_IDX_LF 3'h3
`define CSSW_IDX_HF 3'h4

// ---------------------------------------------------------------
// start-up counts in source cycles
// ---------------------------------------------------------------
`define CSSW_CK_6 17'h00006
`define CSSW_CK_14 17'h0000E
`define CSSW_CK_258 17'h00102
`define CSSW_CK_1K 17'h00400
`define CSSW_CK_16K 17'h04000
`define CSSW_CK_32K 17'h08000

// ---------------------------------------------------------------
// reset delay in watchdog oscillator cycles (4.1 ms / 65 ms)
// ---------------------------------------------------------------
`define CSSW_WDT_SHORT 16'h0200
`define CSSW_WDT_LONG 16'h2000

// ---------------------------------------------------------------
// misc timing in core cycles
// ---------------------------------------------------------------
`define CSSW_INIT_WAIT 2'h3
`define CSSW_CCE_WIN 3'h4

`endif

// ---- hw/cssw_pkg.sv ----
`include "cssw_map.svh"

package cssw_pkg;

  typedef enum logic [1:0] {
    CSSW_ST_INIT = 2'b00,
    CSSW_ST_RDLY = 2'b01,
    CSSW_ST_START = 2'b10,
    CSSW_ST_RUN = 2'b11
  } cssw_state_t;

  typedef enum logic [3:0] {
    CSSW_CMD_NONE = 4'h0,
    CSSW_CMD_DIS = 4'h1,
    CSSW_CMD_EN = 4'h2,
    CSSW_CMD_REQ = 4'h3,
    CSSW_CMD_SW = 4'h4,
    CSSW_CMD_REC = 4'h5
  } cssw_cmd_t;

  typedef enum logic [1:0] {
    CSSW_DLY_NONE = 2'b00,
    CSSW_DLY_SHORT = 2'b01,
    CSSW_DLY_LONG = 2'b10
  } cssw_dly_t;

  typedef struct packed {
    cssw_state_t state;
    logic [1:0] init_cnt;
    logic [3:0] source_select_field;
    logic [1:0] startup_field;
    logic clock_out_bit;
    logic rstdis;
    logic cce;
    logic [2:0] cce_win;
    logic rdy;
    logic busy;
    logic [2:0] cidx;
    logic [16:0] cnt;
    logic [16:0] limit;
    logic [15:0] wcnt;
    logic [15:0] wlimit;
    logic [3:0] active;
    logic [4:0] src_en;
    logic [4:0] oen;
    logic [1:0] hf_mode;
    logic [2:0] sys_idx;
    logic [4:0] ck_s1;
    logic [4:0] ck_s2;
    logic [4:0] ck_s3;
    logic [7:0] fz_s1;
    logic [7:0] fz_s2;
    logic [1:0] tm_s1;
    logic [1:0] tm_s2;
    logic wait_n;
    logic [31:0] rdata;
    logic hold;
    logic ck_out;
    logic ck_oe;
  } cssw_regs_t;

endpackage : cssw_pkg

// ---- verif/cssw_props.sv ----
`timescale 1ns/100ps
`include "cssw_map.svh"

// ---------------------------------------------------------------
// port-level checker
// ---------------------------------------------------------------
module cssw_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // source control and clock output
  input wire logic sysclk_div_i,
  input wire logic [4:0] src_en_o,
  input wire logic [2:0] sys_src_o,
  input wire logic cpu_hold_o,
  input wire logic clock_output_pin_o,
  input wire logic clock_output_pin_oe_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // reset itself is the antecedent, so this one is never disabled
  property p_rst_out;
    disable iff (1'b0) rst_i |=> avs_waitrequest_o && cpu_hold_o
      && !clock_output_pin_oe_o && src_en_o == 5'h00;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not in reset state");

  property p_boot_hold;
    $fell(rst_i) |-> cpu_hold_o [*8];
  endproperty
  a_boot_hold: assert property (p_boot_hold)
    else $error("execution released too early after reset");

  property p_div_out;
    clock_output_pin_oe_o |-> clock_output_pin_o == $past(sysclk_div_i);
  endproperty
  a_div_out: assert property (p_div_out)
    else $error("clock pin does not follow divided clock");

  property p_hold_gate;
    cpu_hold_o && $past(cpu_hold_o) |-> !clock_output_pin_oe_o;
  endproperty
  a_hold_gate: assert property (p_hold_gate)
    else $error("clock pin driven while held");

  // the enable and sys_src_o are registered in the same cycle from the active source
  property p_xtal_gate;
    sys_src_o inside {`CSSW_IDX_LF, `CSSW_IDX_HF} && $stable(sys_src_o)
      |-> !clock_output_pin_oe_o;
  endproperty
  a_xtal_gate: assert property (p_xtal_gate)
    else $error("clock pin driven on crystal source");

  property p_sys_on;
    !cpu_hold_o |-> src_en_o[sys_src_o];
  endproperty
  a_sys_on: assert property (p_sys_on)
    else $error("system source not enabled");

  property p_sys_cmd;
    $changed(sys_src_o) && !cpu_hold_o && !$past(cpu_hold_o)
      |-> $past(avs_write_i) || $past(avs_write_i, 2);
  endproperty
  a_sys_cmd: assert property (p_sys_cmd)
    else $error("system source changed without a write");

  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");

  property p_wait_ans;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("access not answered after one wait cycle");

  property p_rd_zero;
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000
      && (avs_address_i inside {`CSSW_ADR_SEL, `CSSW_ADR_CMD, `CSSW_ADR_STAT}
      || avs_readdata_o == 32'h00000000);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unused read bits not zero");

  c_hf: cover property (sys_src_o == `CSSW_IDX_HF);
  c_oe: cover property ($rose(clock_output_pin_oe_o));
  c_boot: cover property ($fell(cpu_hold_o));
endmodule : cssw_props

bind cssw_top cssw_props u_props (
  .core_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_readdata_o, .avs_waitrequest_o, .sysclk_div_i, .src_en_o,
  .sys_src_o, .cpu_hold_o, .clock_output_pin_o, .clock_output_pin_oe_o
);

// ---- verif/cssw_osc_model.sv ----
`timescale 1ns/100ps

// ---------------------------------------------------------------
// oscillators and clock driver on the far side
// ---------------------------------------------------------------
module cssw_osc_model (
  // enables from the block
  input wire logic [4:0] en_i,
  input wire logic slow_i,
  // raw source clocks
  output logic [4:0] clk_o
);
  // half periods in ns, all at least three core cycles
  int half [5] = '{28, 52, 36, 60, 28};

  initial clk_o = 5'h00;

  for (genvar i = 0; i < 5; i++) begin : g_osc
    // rc and watchdog oscillators are on-chip and never gated here
    always begin
      if (en_i[i] === 1'b1 || i < 2) begin
        #(slow_i ? 2 * half[i] : half[i]);
        clk_o[i] = ~clk_o[i];
      end else begin
        // a stopped oscillator rests low, it keeps no last level
        clk_o[i] = 1'b0;
        @(en_i[i]);
      end
    end
  end
endmodule : cssw_osc_model

// ---- verif/cssw_tb.sv ----
`timescale 1ns/100ps
`include "cssw_map.svh"

module testbench
  import cssw_pkg::*;
;
  // 16k count shortened to 32; an enable counts start-up cycles only,
  // the 14-cycle part belongs to the delay from reset
  localparam int HF_LIM = 32;
  logic core_clk_i, rst_i, avs_read_i, avs_write_i, sysclk_div_i, slow;
  logic avs_waitrequest_o, cpu_hold_o, pin, pin_oe, cko_f, rdis_f;
  logic tmr_lf, tmr_ext, wake;
  logic [3:0] avs_address_i, sel_f;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [4:0] src_clk, src_en_o;
  logic [1:0] hf_mode_o, sut_f;
  logic [2:0] sys_src_o;
  int n_fail, total_checks, hf_edges, wdt_edges;

  cssw_top #(.SRC_CK_16K(17'h00020), .SRC_CK_32K(17'h00040),
    .WDT_LONG(16'h0010)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .src_clk_i(src_clk),
    .source_select_fuse_i(sel_f), .startup_fuse_i(sut_f),
    .clock_out_fuse_i(cko_f), .reset_pin_disable_fuse_i(rdis_f),
    .tmr_lf_req_i(tmr_lf), .tmr_ext_req_i(tmr_ext), .wake_i(wake),
    .sysclk_div_i(sysclk_div_i), .src_en_o(src_en_o),
    .hf_mode_o(hf_mode_o), .sys_src_o(sys_src_o), .cpu_hold_o(cpu_hold_o),
    .clock_output_pin_o(pin), .clock_output_pin_oe_o(pin_oe)
  );

  cssw_osc_model u_osc (.en_i(src_en_o), .slow_i(slow), .clk_o(src_clk));

  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) sysclk_div_i <= ~sysclk_div_i;
  always @(posedge src_clk[4]) hf_edges++;
  always @(posedge src_clk[1]) wdt_edges++;

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  // leaves the strobe up so a second access can follow back to back
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h000000, d};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    chk("bus answer", 32'h0, avs_waitrequest_o);
    q = avs_readdata_o;
  endtask : bus

  task automatic idle;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : idle

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    idle();
  endtask : wr

  task automatic rd(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
    idle();
  endtask : rd

  task automatic cmd(input logic [3:0] c);
    bus(1'b1, `CSSW_ADR_CMD, 8'h80);
    bus(1'b1, `CSSW_ADR_CMD, {4'h0, c});
    idle();
    cyc(2);
  endtask : cmd

  task automatic wait_hold;
    int n;
    n = 0;
    while (cpu_hold_o !== 1'b0 && n < 30000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("hold release", 32'h0, cpu_hold_o);
  endtask : wait_hold

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      rd(`CSSW_ADR_CMD);
      n++;
    end while (q[4] !== 1'b1 && n < 300);
    chk("ready flag", 32'h1, q[4]);
  endtask : wait_rdy

  task automatic tally_and_finish;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    #400000;
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    tally_and_finish();
  end

  initial begin
    {core_clk_i, avs_read_i, avs_write_i, sysclk_div_i, slow} = 5'h00;
    {tmr_lf, tmr_ext, cko_f, rdis_f, wake} = 5'h00;
    rst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h00000000;
    sel_f = 4'h2;
    sut_f = 2'h0;
    {n_fail, total_checks, hf_edges, wdt_edges} = '0;
    cyc(3);
    chk("reset outputs", 32'hC0, {avs_waitrequest_o, cpu_hold_o, pin_oe,
      src_en_o});
    rst_i <= 1'b0;
    wait_hold();
    rd(`CSSW_ADR_SEL);
    chk("select reg", 32'h42, q);
    chk("boot source", `CSSW_IDX_RC, sys_src_o);
    chk("clock out on", 32'h1, pin_oe);
    for (int m = 4; m < 8; m++) begin
      wr(`CSSW_ADR_SEL, 8'(8'h51 | (m << 1)));
      cyc(2);
      chk("hf mode", m & 3, hf_mode_o);
    end
    wr(`CSSW_ADR_CMD, 8'h02);
    cyc(2);
    chk("unguarded enable", 32'h0, src_en_o[4]);
    hf_edges = 0;
    cmd(4'h2);
    chk("hf enable", 32'h1, src_en_o[4]);
    rd(`CSSW_ADR_CMD);
    chk("ready at start", 32'h0, q[4]);
    cmd(4'h1);
    chk("busy refusal", 32'h1, src_en_o[4]);
    wait_rdy();
    chk("hf count", 32'h1, hf_edges >= HF_LIM && hf_edges <= HF_LIM + 6);
    tmr_lf <= 1'b1;
    tmr_ext <= 1'b1;
    cyc(8);
    chk("timer grants", 32'h2, src_en_o[3:2]);
    tmr_lf <= 1'b0;
    tmr_ext <= 1'b0;
    cmd(4'h4);
    chk("switch to hf", `CSSW_IDX_HF, sys_src_o);
    chk("clock out on crystal", 32'h0, pin_oe);
    wr(`CSSW_ADR_SEL, 8'h42);
    cmd(4'h5);
    rd(`CSSW_ADR_SEL);
    chk("recovered source", 32'h4F, q);
    cmd(4'h1);
    chk("active disable", 32'h1, src_en_o[4]);
    wr(`CSSW_ADR_SEL, 8'h42);
    cmd(4'h3);
    wait_rdy();
    cmd(4'h4);
    chk("switch to rc", `CSSW_IDX_RC, sys_src_o);
    chk("clock out back", 32'h1, pin_oe);
    wr(`CSSW_ADR_SEL, 8'h4F);
    cmd(4'h1);
    chk("hf disable", 32'h0, src_en_o[4]);
    tmr_ext <= 1'b1;
    cyc(8);
    chk("timer ext grant", 32'h1, src_en_o[2]);
    tmr_ext <= 1'b0;
    // wake-up re-times the rc source: 6 edges, no reset delay
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(2);
    chk("wake hold", 32'h1, cpu_hold_o);
    wait_hold();
    rd(4'hC);
    rd(`CSSW_ADR_STAT);
    chk("run status", 32'h3, q[14:12]);
    // second boot: external clock, slow sources, reset pin disabled
    {sel_f, sut_f, cko_f, rdis_f, slow} <= 9'h007;
    rst_i <= 1'b1;
    cyc(3);
    rst_i <= 1'b0;
    wdt_edges = 0;
    cyc(12);
    rd(`CSSW_ADR_STAT);
    chk("delay state", 32'h1, q[13:12]);
    wait_hold();
    chk("delay length", 32'h1, wdt_edges >= 512 && wdt_edges <= 560);
    rd(`CSSW_ADR_SEL);
    chk("fuse copy", 32'h00, q);
    chk("clock out off", 32'h0, pin_oe);
    tally_and_finish();
  end
endmodule : testbench
